// ==== dlts_bank.sv ====
// lane timing, bypass, status and error bank behind an indirect window
// ---------------------------------------------------------------------
// behaviour notes and interface
// ---------------------------------------------------------------------
// Notes on behaviour
// - after power up wait (programmed 3-bit value plus one) times 100 us
// - clock settle is 7-bit count in 10 ns steps, reset 1Dh
// - hs data settle is 7-bit count in 10 ns steps, reset 14h
// - after end of transmission drop skip-count DDR clocks of data, reset 1Dh
// - hs receive timeout counts milliseconds; value N expires N ms after the burst starts
// - a timeout value of zero turns the timeout off
// - termination enable delay is a 3-bit count resetting to zero
// - bypass bit 7 skips init wait; bit 6 skips clock-miss check
// - bypass bit 5 skips ultra-low-power handling on the clock lane
// - five bypass bits skip low-power signalling per clock and data lane
// - set sync error when enabled lanes do not sync together
// - on sync error snapshot each data lane's sync status for software
// - summary flag bit 5 is set while any lane 0 error flag is set
// - summary flag clears once software has read the lane 0 error register
// - status bit 4 shows clock lane active
// - status bits 3..0 show each data lane active
// - lane 0 error bit 4 flags uncorrectable end sync error
// - lane 0 error bit 3 flags correctable start sync bit error
// - lane 0 error bit 2 flags uncorrectable start sync error
// - lane 0 error bit 1 flags control error in hs request mode
// - lane 0 error bit 0 flags hs receive timeout
// - with auto-increment each data access advances the offset by one
module dlts_bank
  import dlts_pkg::*;
#(
  parameter int INIT_STEP = dlts_pkg::INIT_STEP_CYC,
  parameter int MS_STEP = dlts_pkg::MS_STEP_CYC,
  parameter logic [1:0] PORT_ID = 2'd0
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // indirect access window
  input wire dlts_pkg::dlts_access_type ACCESS,
  output logic [7:0] RDATA,
  // link clock pin (asynchronous, sampled for edges)
  input wire logic LINK_CLK,
  // data lane levels (asynchronous)
  input wire logic [3:0] LANE_ACTIVE,
  input wire logic [3:0] LANE_SYNC,
  input wire logic LANE_SOT,
  input wire logic [3:0] LANE_EOT,
  // lane 0 fault events from the lane receiver (same domain)
  input wire dlts_pkg::dlts_lane_fault_type LANE0_FAULT,
  // controls out to the lane receivers
  output logic LANES_READY,
  output logic [6:0] CLK_SETTLE_CYC,
  output logic [6:0] HS_SETTLE_CYC,
  output logic [2:0] TERM_ENABLE_CNT,
  output logic [5:0] EOT_SKIP_CNT,
  output logic [4:0] LP_POLARITY,
  output logic [4:0] LP_BYPASS,
  output logic CLK_MISS_BYPASS,
  output logic CLK_ULP_BYPASS,
  // one-cycle pulse when a burst overruns its timeout
  output logic HS_TIMEOUT
);
  import dlts_pkg::*;

  // ---------------------------------------------------------------------
  // state and synchronised pins
  // ---------------------------------------------------------------------
  typedef struct packed {
    // indirect window
    logic [7:0] ctl;
    logic [7:0] addr;
    logic [7:0] rdata;
    // configuration registers
    logic [7:0] init_wait;
    logic [7:0] term_delay;
    logic [7:0] clk_settle;
    logic [7:0] hs_settle;
    logic [7:0] eot_skip;
    logic [7:0] lp_pol;
    logic [7:0] bypass;
    logic [7:0] hs_to;
    // sticky flags, snapshot and lane activity
    logic sync_err;
    logic [3:0] sync_snap;
    logic [4:0] lane0_err;
    logic any_fault;
    logic [3:0] lane_act;
    // power-up wait
    logic [31:0] init_cnt;
    logic [2:0] init_steps;
    logic ready;
    // receive timeout
    logic [31:0] ms_cnt;
    logic [7:0] ms_left;
    logic hs_to_pulse;
    // clock-lane activity
    logic link_prev;
    logic [6:0] link_edges;
    // a burst was running with a non-zero timeout on the previous cycle
    logic in_burst;
  } dlts_bank_state_type;

  dlts_bank_state_type st;
  dlts_bank_state_type next_st;

  // pin levels after the two-flop synchroniser
  logic link_s;
  logic [3:0] active_s;
  logic [3:0] sync_s;
  logic sot_s;
  logic [3:0] eot_s;

  // ---------------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------------
  // every pin-level input is brought into CLK_SYS by two flops
  dlts_sync #(.WIDTH(14)) u_pins (
    .CLK_SYS(CLK_SYS),
    .SRST(SRST),
    .din({LINK_CLK, LANE_ACTIVE, LANE_SYNC, LANE_SOT, LANE_EOT}),
    .dout({link_s, active_s, sync_s, sot_s, eot_s})
  );

  // ---------------------------------------------------------------------
  // register access helpers
  // ---------------------------------------------------------------------
  // read multiplexer; reserved bits come back as zero
  function automatic logic [7:0] read_reg(input dlts_bank_state_type s,
                                          input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OFS_INIT_WAIT: v = s.init_wait;
      OFS_TERM_DELAY: v = s.term_delay;
      OFS_CLK_SETTLE: v = s.clk_settle;
      OFS_HS_SETTLE: v = s.hs_settle;
      OFS_EOT_SKIP: v = s.eot_skip;
      OFS_LP_POLARITY: v = s.lp_pol;
      OFS_BYPASS: v = s.bypass;
      OFS_HS_TIMEOUT: v = s.hs_to;
      OFS_LANE_STATUS: begin
        v[BIT_SYNC_ERR] = s.sync_err;
        v[BIT_ANY_FAULT] = s.any_fault;
        v[BIT_CLK_ACTIVE] = s.link_edges != 7'h00;
        // data lane activity as last sampled, one bit per lane
        v[3:0] = s.lane_act;
      end
      OFS_LANE0_ERR: v = {3'h0, s.lane0_err};
      OFS_SYNC_SNAP: v = {4'h0, s.sync_snap};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // masked write of one byte
  function automatic logic [7:0] wr_masked(input logic [7:0] d,
                                           input logic [7:0] m);
    return d & m;
  endfunction : wr_masked

  // true on the last cycle of a step that lasts the given cycles
  function automatic logic step_done(input logic [31:0] cnt,
                                     input int step);
    return cnt >= 32'(step - 1);
  endfunction : step_done

  // ---------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------
  // decode helpers, recomputed every cycle
  logic selected;
  logic data_access;
  logic [7:0] rd_value;
  logic init_done;

  always_comb begin
    next_st = st;
    // only the port whose select bit is set answers data accesses; control and offset writes reach every port
    selected = PORT_ID == 2'd0 ? st.ctl[BIT_CTL_PORT0] :
                                 st.ctl[BIT_CTL_PORT1];
    data_access = selected && (ACCESS.wr_data || ACCESS.rd_data);
    rd_value = read_reg(st, st.addr);
    init_done = 1'b0;
    next_st.hs_to_pulse = 1'b0;

    // control and offset writes
    if (ACCESS.wr_ctl) begin
      next_st.ctl = ACCESS.wdata;
    end
    if (ACCESS.wr_addr) begin
      next_st.addr = ACCESS.wdata;
    end else if (data_access && st.ctl[BIT_CTL_AUTOINC]) begin
      next_st.addr = st.addr + 8'h01;
    end

    // data writes into the writable fields
    if (selected && ACCESS.wr_data) begin
      case (st.addr)
        OFS_INIT_WAIT: next_st.init_wait =
          wr_masked(ACCESS.wdata, MSK_INIT_WAIT);
        OFS_TERM_DELAY: next_st.term_delay =
          wr_masked(ACCESS.wdata, MSK_TERM_DELAY);
        OFS_CLK_SETTLE: next_st.clk_settle =
          wr_masked(ACCESS.wdata, MSK_SETTLE);
        OFS_HS_SETTLE: next_st.hs_settle =
          wr_masked(ACCESS.wdata, MSK_SETTLE);
        OFS_EOT_SKIP: next_st.eot_skip =
          wr_masked(ACCESS.wdata, MSK_EOT_SKIP);
        OFS_LP_POLARITY: next_st.lp_pol =
          wr_masked(ACCESS.wdata, MSK_LP_POLARITY);
        OFS_BYPASS: next_st.bypass =
          ACCESS.wdata;
        OFS_HS_TIMEOUT: next_st.hs_to =
          ACCESS.wdata;
        // unmapped and read-only offsets drop the write
        default: ;
      endcase
    end

    // reads return the addressed byte, then clear read-to-clear flags;
    // a fault arriving in the same cycle is applied after, so set wins
    if (selected && ACCESS.rd_data) begin
      next_st.rdata = rd_value;
      if (st.addr == OFS_LANE_STATUS) begin
        next_st.sync_err = 1'b0;
      end
      if (st.addr == OFS_LANE0_ERR) begin
        next_st.lane0_err = 5'h00;
      end
    end

    // sticky lane 0 faults, one bit per event kind
    next_st.lane0_err = next_st.lane0_err | {LANE0_FAULT.end_sync,
      LANE0_FAULT.start_bit,
      LANE0_FAULT.start_sync,
      LANE0_FAULT.hs_request,
      LANE0_FAULT.hs_timeout | st.hs_to_pulse};

    // sync check at start of transmission across active lanes; it looks
    // at the level, so a lasting mismatch sets the flag again after a read
    if (sot_s && ((sync_s & active_s) != active_s)) begin
      next_st.sync_err = 1'b1;
      next_st.sync_snap = sync_s;
    end

    // summary follows the sticky lane 0 flags, cleared with them by reads
    next_st.any_fault = next_st.lane0_err != 5'h00;

    // data lane activity, held one cycle so reads see a flop
    next_st.lane_act = active_s;

    // power-up wait in 100 us steps, skippable by bypass bit 7;
    // a wide step counter costs flops but suits any system clock rate
    if (!st.ready) begin
      if (st.bypass[BIT_SKIP_INIT]) begin
        init_done = 1'b1;
      end else if (step_done(st.init_cnt, INIT_STEP)) begin
        next_st.init_cnt = 32'h0;
        if (st.init_steps >= st.init_wait[2:0]) begin
          init_done = 1'b1;
        end else begin
          next_st.init_steps = st.init_steps + 3'h1;
        end
      end else begin
        next_st.init_cnt = st.init_cnt + 32'h1;
      end
      next_st.ready = init_done;
    end

    // link clock edges mark a live clock lane; decays when it stops.
    // 127 cycles outlast half a link period, so a running clock never
    // lets the flag drop between edges
    next_st.link_prev = link_s;
    if (link_s != st.link_prev) begin
      next_st.link_edges = 7'h7F;
    end else if (st.link_edges != 7'h00) begin
      next_st.link_edges = st.link_edges - 7'h01;
    end

    // hs burst timeout: ms ticks restart with each burst, so expiry lands at N ms;
    // pin synchronisation adds a few cycles, far below one tick
    next_st.in_burst = (active_s != 4'h0) && st.hs_to != 8'h00;
    if (!st.in_burst || st.hs_to == 8'h00) begin
      next_st.ms_cnt = 32'h0;
      next_st.ms_left = st.hs_to;
    end else if (step_done(st.ms_cnt, MS_STEP)) begin
      next_st.ms_cnt = 32'h0;
      if (st.ms_left <= 8'h01) begin
        next_st.hs_to_pulse = st.ms_left == 8'h01;
        next_st.ms_left = 8'h00;
      end else begin
        next_st.ms_left = st.ms_left - 8'h01;
      end
    end else begin
      next_st.ms_cnt = st.ms_cnt + 32'h1;
    end
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  // synchronous reset clears everything, then loads non-zero defaults
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st <= '0;
      st.clk_settle <= RST_CLK_SETTLE;
      st.hs_settle <= RST_HS_SETTLE;
      st.eot_skip <= RST_EOT_SKIP;
      st.init_wait <= RST_ZERO;
      st.term_delay <= RST_ZERO;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  // read data byte, registered when the read was taken
  logic [7:0] status_live;
  always_comb begin
    status_live = st.rdata;
  end

  // window and handshake outputs straight from state flops
  assign RDATA = status_live;
  assign LANES_READY = st.ready;

  // field copies for the lane receivers
  assign CLK_SETTLE_CYC = st.clk_settle[6:0];
  assign HS_SETTLE_CYC = st.hs_settle[6:0];
  assign TERM_ENABLE_CNT = st.term_delay[2:0];
  assign EOT_SKIP_CNT = st.eot_skip[6:1];
  assign LP_POLARITY = st.lp_pol[4:0];
  assign LP_BYPASS = st.bypass[4:0];
  assign CLK_MISS_BYPASS = st.bypass[BIT_SKIP_CLK_MISS];
  assign CLK_ULP_BYPASS = st.bypass[BIT_SKIP_CLK_ULP];
  assign HS_TIMEOUT = st.hs_to_pulse;

  // end-of-transmission levels are synchronised for later use; folded
  // here so the unused flops stay visible as deliberate
  logic unused_eot;
  assign unused_eot = ^eot_s;
endmodule : dlts_bank

// ==== dlts_bank_bench.sv ====
// self-checking bench for the lane timing bank
module dlts_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import dlts_pkg::*;
  logic clk_sys, l_clk, l_sot, ready, hs_to, cmiss, culp;
  logic srst = 1'h1;
  logic run = 1'h0;
  logic [3:0] lanes = 4'h0;
  logic [3:0] skew = 4'h0;
  logic [3:0] l_act, l_sync, l_eot;
  dlts_access_type access = '0;
  dlts_lane_fault_type fault = '0;
  logic [7:0] rdata;
  logic [6:0] cset, hset;
  logic [2:0] term;
  logic [5:0] skip;
  logic [4:0] lpol, lbyp;
  int fail_count, n_compared, n_to, i;
  logic [7:0] ofs [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h0F, 8'h10};
  logic [7:0] rst_v [10] = '{8'h00, 8'h00, 8'h1D, 8'h14, 8'h3A, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [8] = '{8'h07, 8'h07, 8'h7F, 8'h7F, 8'h7E, 8'h1F,
    8'hFF, 8'hFF};
  // short init and ms steps keep the run brief
  dlts_bank #(.INIT_STEP(4), .MS_STEP(8), .PORT_ID(2'h0)) u_dut (
    .CLK_SYS(clk_sys), .SRST(srst), .ACCESS(access), .RDATA(rdata),
    .LINK_CLK(l_clk), .LANE_ACTIVE(l_act), .LANE_SYNC(l_sync),
    .LANE_SOT(l_sot), .LANE_EOT(l_eot), .LANE0_FAULT(fault),
    .LANES_READY(ready), .CLK_SETTLE_CYC(cset), .HS_SETTLE_CYC(hset),
    .TERM_ENABLE_CNT(term), .EOT_SKIP_CNT(skip), .LP_POLARITY(lpol),
    .LP_BYPASS(lbyp), .CLK_MISS_BYPASS(cmiss), .CLK_ULP_BYPASS(culp),
    .HS_TIMEOUT(hs_to));
  dlts_src_model u_src (.run(run), .lanes(lanes), .skew(skew),
    .link_clk(l_clk), .active(l_act), .sync(l_sync), .sot(l_sot),
    .eot(l_eot));
  // system clock, and a count of timeout pulses
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (hs_to === 1'h1) n_to++;
  // one strobe cycle then one idle cycle, so no strobe is set twice
  task automatic acc(input logic [3:0] k, input logic [7:0] d);
    access <= {k, d};
    @(posedge clk_sys);
    access <= '0;
    @(posedge clk_sys);
  endtask : acc
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h want %h", $time, g, e);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(4'h8, 8'h04);
    acc(4'h4, a);
    acc(4'h2, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(4'h8, 8'h05);
    acc(4'h4, a);
    acc(4'h1, 8'h00);
    chk(rdata, e);
  endtask : rd
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    $display("unexpected at %0t: run did not finish", $time);
    fail_count++;
    report_and_stop;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk({7'h0, ready}, 8'h00);
    repeat (8) @(posedge clk_sys);
    chk({7'h0, ready}, 8'h01);
    for (i = 0; i < 10; i++) rd(ofs[i], rst_v[i]);
    for (i = 0; i < 8; i++) wr(ofs[i], 8'hFF);
    for (i = 0; i < 8; i++) rd(ofs[i], msk[i]);
    chk({lbyp, cmiss, culp, 1'h0}, 8'hFE);
    chk({2'h0, skip}, 8'h3F);
    chk({5'h0, term}, 8'h07);
    chk({1'h0, cset}, 8'h7F);
    chk({1'h0, hset}, 8'h7F);
    chk({3'h0, lpol}, 8'h1F);
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'h00);
    wr(8'h07, 8'h00);
    wr(8'h08, 8'h00);
    // data write with the other port selected must be dropped
    acc(4'h8, 8'h08);
    acc(4'h4, 8'h01);
    acc(4'h2, 8'h00);
    rd(8'h01, 8'h07);
    acc(4'h8, 8'h07);
    acc(4'h4, 8'h03);
    for (i = 0; i < 3; i++) begin
      acc(4'h1, 8'h00);
      chk(rdata, msk[i + 2]);
    end
    for (i = 0; i < 5; i++) begin
      fault <= 5'h01 << i;
      @(posedge clk_sys);
      fault <= '0;
      @(posedge clk_sys);
      rd(8'h0F, 8'h20);
      rd(8'h10, 8'h01 << i);
      rd(8'h10, 8'h00);
      rd(8'h0F, 8'h00);
    end
    lanes <= 4'hF;
    run <= 1'h1;
    repeat (40) @(posedge clk_sys);
    rd(8'h0F, 8'h1F);
    skew <= 4'h2;
    repeat (20) @(posedge clk_sys);
    rd(8'h0F, 8'h5F);
    run <= 1'h0;
    repeat (200) @(posedge clk_sys);
    rd(8'h15, 8'h0D);
    rd(8'h0F, 8'h40);
    rd(8'h0F, 8'h00);
    skew <= 4'h0;
    run <= 1'h1;
    n_to = 0;
    repeat (60) @(posedge clk_sys);
    chk(n_to[7:0], 8'h00);
    wr(8'h08, 8'h02);
    for (i = 0; i < 40 && n_to == 0; i++) @(posedge clk_sys);
    chk({7'h0, n_to > 0}, 8'h01);
    chk({7'h0, i >= 8 && i <= 20}, 8'h01);
    run <= 1'h0;
    repeat (200) @(posedge clk_sys);
    rd(8'h10, 8'h01);
    report_and_stop;
  end
endmodule : dlts_bank_bench

// ==== dlts_bank_monitor.sv ====
// assertion checker for the lane timing bank
module dlts_bank_monitor
  import dlts_pkg::*;
#(
  parameter int INIT_STEP = 4,
  parameter int MS_STEP = 8
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // access window
  input wire dlts_pkg::dlts_access_type ACCESS,
  input wire logic [7:0] RDATA,
  // controls out
  input wire logic LANES_READY,
  input wire logic [6:0] CLK_SETTLE_CYC,
  input wire logic [6:0] HS_SETTLE_CYC,
  input wire logic [2:0] TERM_ENABLE_CNT,
  input wire logic [5:0] EOT_SKIP_CNT,
  input wire logic [4:0] LP_POLARITY,
  input wire logic [4:0] LP_BYPASS,
  input wire logic CLK_MISS_BYPASS,
  input wire logic CLK_ULP_BYPASS,
  input wire logic HS_TIMEOUT
);
  int since_rst;
  // saturating age since reset; a timeout can never beat one ms step
  always_ff @(posedge CLK_SYS) begin
    if (SRST) since_rst <= 0;
    else if (since_rst < MS_STEP) since_rst <= since_rst + 1;
  end
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // first edge after reset, and a cycle with no data write
  sequence s_fresh;
    $past(SRST);
  endsequence
  sequence s_no_write;
    !ACCESS.wr_data;
  endsequence
  settle_rst_a:
    assert property (s_fresh |-> CLK_SETTLE_CYC == 7'h1D &&
      HS_SETTLE_CYC == 7'h14 && EOT_SKIP_CNT == 6'h1D)
    else $error("settle or skip count not at reset value");
  zero_rst_a:
    assert property (s_fresh |-> TERM_ENABLE_CNT == 3'h0 &&
      LP_BYPASS == 5'h0 && LP_POLARITY == 5'h0 && !CLK_ULP_BYPASS)
    else $error("zero-reset field not zero");
  ready_rst_a:
    assert property (s_fresh |-> !LANES_READY)
    else $error("lanes ready without init wait");
  ready_hold_a:
    assert property (LANES_READY |=> LANES_READY)
    else $error("lanes ready dropped");
  fields_hold_a:
    assert property (s_no_write |=> $stable({CLK_SETTLE_CYC,
      HS_SETTLE_CYC, TERM_ENABLE_CNT, EOT_SKIP_CNT, LP_BYPASS,
      CLK_MISS_BYPASS, CLK_ULP_BYPASS}))
    else $error("control field changed without write");
  rdata_hold_a:
    assert property (!ACCESS.rd_data |=> $stable(RDATA))
    else $error("read data moved without read");
  timeout_pulse_a:
    assert property (HS_TIMEOUT |=> !HS_TIMEOUT)
    else $error("timeout pulse too long");
  timeout_early_a:
    assert property (HS_TIMEOUT |-> since_rst >= MS_STEP)
    else $error("timeout before one ms step");
endmodule : dlts_bank_monitor

bind dlts_bank dlts_bank_monitor #(
  .INIT_STEP(INIT_STEP),
  .MS_STEP(MS_STEP)
) u_mon (
  .CLK_SYS, .SRST, .ACCESS, .RDATA, .LANES_READY, .CLK_SETTLE_CYC,
  .HS_SETTLE_CYC, .TERM_ENABLE_CNT, .EOT_SKIP_CNT, .LP_POLARITY,
  .LP_BYPASS, .CLK_MISS_BYPASS, .CLK_ULP_BYPASS, .HS_TIMEOUT
);

// ==== dlts_pkg.sv ====
// package: register map, field layout, resets and timing for the lane bank
package dlts_pkg;

  // register offsets inside the indirect window
  localparam logic [7:0] OFS_INIT_WAIT = 8'h01;
  localparam logic [7:0] OFS_TERM_DELAY = 8'h02;
  localparam logic [7:0] OFS_CLK_SETTLE = 8'h03;
  localparam logic [7:0] OFS_HS_SETTLE = 8'h04;
  localparam logic [7:0] OFS_EOT_SKIP = 8'h05;
  localparam logic [7:0] OFS_LP_POLARITY = 8'h06;
  localparam logic [7:0] OFS_BYPASS = 8'h07;
  localparam logic [7:0] OFS_HS_TIMEOUT = 8'h08;
  localparam logic [7:0] OFS_LANE_STATUS = 8'h0F;
  localparam logic [7:0] OFS_LANE0_ERR = 8'h10;
  localparam logic [7:0] OFS_LANE1_ERR = 8'h11;
  localparam logic [7:0] OFS_LANE2_ERR = 8'h12;
  localparam logic [7:0] OFS_LANE3_ERR = 8'h13;
  localparam logic [7:0] OFS_CLK_ERR = 8'h14;
  localparam logic [7:0] OFS_SYNC_SNAP = 8'h15;

  // reset values
  localparam logic [7:0] RST_CLK_SETTLE = 8'h1D;
  localparam logic [7:0] RST_HS_SETTLE = 8'h14;
  localparam logic [7:0] RST_EOT_SKIP = 8'h3A;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // writable masks (reserved bits read as zero)
  localparam logic [7:0] MSK_INIT_WAIT = 8'h07;
  localparam logic [7:0] MSK_TERM_DELAY = 8'h07;
  localparam logic [7:0] MSK_SETTLE = 8'h7F;
  localparam logic [7:0] MSK_EOT_SKIP = 8'h7E;
  localparam logic [7:0] MSK_LP_POLARITY = 8'h1F;
  localparam logic [7:0] MSK_FULL = 8'hFF;

  // field positions
  localparam int BIT_SKIP_INIT = 7;
  localparam int BIT_SKIP_CLK_MISS = 6;
  localparam int BIT_SKIP_CLK_ULP = 5;
  localparam int BIT_SYNC_ERR = 6;
  localparam int BIT_ANY_FAULT = 5;
  localparam int BIT_CLK_ACTIVE = 4;

  // indirect control fields: bit 0 read, bit 1 auto-increment, 2/3 port
  localparam int BIT_CTL_AUTOINC = 1;
  localparam int BIT_CTL_PORT0 = 2;
  localparam int BIT_CTL_PORT1 = 3;

  // timing at a 250 MHz system clock
  localparam int CLK_PERIOD_PS = 4000;
  localparam int INIT_STEP_US = 100;
  localparam int INIT_STEP_CYC = INIT_STEP_US * 1000000 / CLK_PERIOD_PS;
  localparam int MS_STEP_MS = 1;
  localparam int MS_STEP_CYC = MS_STEP_MS * 1000000000 / CLK_PERIOD_PS;
  localparam int SETTLE_STEP_NS = 10;
  localparam int SETTLE_STEP_CYC =
    (SETTLE_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // per-lane fault events from the lane receivers
  typedef struct packed {
    logic end_sync;
    logic start_bit;
    logic start_sync;
    logic hs_request;
    logic hs_timeout;
  } dlts_lane_fault_type;

  // software access strobes into the bank
  typedef struct packed {
    logic wr_ctl;
    logic wr_addr;
    logic wr_data;
    logic rd_data;
    logic [7:0] wdata;
  } dlts_access_type;

endpackage : dlts_pkg

// ==== dlts_src_model.sv ====
// far-side video source model: link clock and lane levels
module dlts_src_model (
  // frame control from the bench
  input wire logic run,
  input wire logic [3:0] lanes,
  input wire logic [3:0] skew,
  // lane pins towards the bank
  output logic link_clk,
  output logic [3:0] active,
  output logic [3:0] sync,
  output logic sot,
  output logic [3:0] eot
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock toggles only inside a frame and parks low between frames
  initial begin
    link_clk = 1'h0;
    #1.3;
    forever begin
      #62.5;
      link_clk = run ? ~link_clk : 1'h0;
    end
  end
  // skewed lanes miss the sync word, so they disagree with the others
  assign active = run ? lanes : 4'h0;
  assign sync = run ? (lanes & ~skew) : 4'h0;
  assign sot = run;
  assign eot = run ? 4'h0 : lanes;
endmodule : dlts_src_model

// ==== dlts_sync.sv ====
// two-flop synchroniser for pin-level inputs
module dlts_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // raw input and synchronised output
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dlts_sync_state_type;

  dlts_sync_state_type st;
  dlts_sync_state_type next_st;

  // first stage feeds only the second stage
  always_comb begin
    next_st.stage1 = din;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stage2;
endmodule : dlts_sync
